// ==== common/spms_pkg.sv ====
/*
  spms_pkg: shared constants, field layouts and types for the serial port
  mode select block and its isolated pulse generator.
  Assumes a 20 MHz core clock; every cycle count below is derived from it.
*/
package spms_pkg;

  // core clock period
  localparam int unsigned CLK_PERIOD_NS = 50;

  // pulse governors and reversal window, in their own unit (ns)
  localparam int unsigned SEL_SPACING_NS = 600;
  localparam int unsigned SEL_SPACING_MAX_NS = 820;
  localparam int unsigned DATA_SEL_NS = 800;
  localparam int unsigned DATA_SEL_MAX_NS = 1050;
  localparam int unsigned BLOCK_NS = 2000;
  localparam int unsigned BLOCK_MAX_NS = 10000;

  // half-pulse widths of the isolated transmitter
  localparam int unsigned CS_HALF_NS = 150;
  localparam int unsigned DATA_HALF_NS = 50;

  // least times round up to whole cycles
  localparam int unsigned SEL_SPACING_CYC = (SEL_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_SEL_CYC = (DATA_SEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLOCK_CYC = (BLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CS_HALF_CYC = (CS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_HALF_CYC = (DATA_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counters are 8 bits wide; the longest window (10 us) is 200 cycles
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] ZERO_CNT = 8'h00;
  localparam logic [CNT_W-1:0] ONE_CNT = 8'h01;
  localparam logic [CNT_W-1:0] SAT_CNT = 8'hff;
  localparam logic [CNT_W-1:0] SEL_SPACING_CNT = CNT_W'(SEL_SPACING_CYC);
  localparam logic [CNT_W-1:0] DATA_SEL_CNT = CNT_W'(DATA_SEL_CYC);
  localparam logic [CNT_W-1:0] BLOCK_CNT = CNT_W'(BLOCK_CYC);
  localparam logic [CNT_W-1:0] CS_HALF_CNT = CNT_W'(CS_HALF_CYC);
  localparam logic [CNT_W-1:0] DATA_HALF_CNT = CNT_W'(DATA_HALF_CYC);

  // widths
  localparam int unsigned ID_W = 4;
  localparam int unsigned GPIO_N = 6;
  localparam int unsigned CMD_W = 8;

  // command byte: chip address field sits in the upper nibble
  localparam int unsigned CMD_ADDR_LSB = 4;
  // spi bit counter: value after the command byte has been taken
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_DONE = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;

  // strapped configuration as seen by the logic
  typedef struct packed {
    logic iso_mode;
    logic daisy_mode;
    logic [ID_W-1:0] chip_id;
  } spms_cfg_t;

  localparam spms_cfg_t CFG_RESET = '{iso_mode: 1'b0, daisy_mode: 1'b0, chip_id: 4'h0};

  // kinds of isolated pulse
  typedef enum logic [1:0] {
    SPMS_CS_RISE = 2'b00,
    SPMS_CS_FALL = 2'b01,
    SPMS_DATA0 = 2'b10,
    SPMS_DATA1 = 2'b11
  } spms_kind_t;

  typedef struct packed {
    spms_kind_t kind;
    logic port_b;
  } spms_tx_req_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } spms_pulse_t;

  typedef enum logic [1:0] {
    SPMS_PG_IDLE = 2'b00,
    SPMS_PG_FIRST = 2'b01,
    SPMS_PG_SECOND = 2'b10
  } spms_pg_state_t;

endpackage : spms_pkg

// ==== rtl/spms_pulse_gen.sv ====
/*
  spms_pulse_gen: shapes one isolated bipolar pulse (first half, then the
  inverted second half) for a chip-select or data symbol.
  Assumes start is only raised while busy is low; runs on core_clk.
*/
`timescale 1ns/1ps
module spms_pulse_gen (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input spms_pkg::spms_kind_t kind,
  output spms_pkg::spms_pulse_t pulse,
  output logic busy,
  output logic done
);

  spms_pkg::spms_pg_state_t state_r;
  logic [spms_pkg::CNT_W-1:0] half_r;
  logic [spms_pkg::CNT_W-1:0] cnt_r;
  logic pos_first_r;
  spms_pkg::spms_pulse_t pulse_r;
  logic is_cs;
  logic pos_first_nxt;
  logic last_tick;

  // chip-select symbols are long pulses, data symbols short ones
  assign is_cs = (kind == spms_pkg::SPMS_CS_RISE) || (kind == spms_pkg::SPMS_CS_FALL);
  assign pos_first_nxt = (kind == spms_pkg::SPMS_CS_RISE) || (kind == spms_pkg::SPMS_DATA1);
  assign last_tick = (cnt_r == spms_pkg::ONE_CNT);

  // half-pulse sequencer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= spms_pkg::SPMS_PG_IDLE;
      half_r <= spms_pkg::ZERO_CNT;
      cnt_r <= spms_pkg::ZERO_CNT;
      pos_first_r <= 1'b0;
    end else begin
      case (state_r)
        spms_pkg::SPMS_PG_IDLE: begin
          if (start) begin
            state_r <= spms_pkg::SPMS_PG_FIRST;
            half_r <= is_cs ? spms_pkg::CS_HALF_CNT : spms_pkg::DATA_HALF_CNT;
            cnt_r <= is_cs ? spms_pkg::CS_HALF_CNT : spms_pkg::DATA_HALF_CNT;
            pos_first_r <= pos_first_nxt;
          end
        end
        spms_pkg::SPMS_PG_FIRST: begin
          if (last_tick) begin
            state_r <= spms_pkg::SPMS_PG_SECOND;
            cnt_r <= half_r;
          end else begin
            cnt_r <= cnt_r - spms_pkg::ONE_CNT;
          end
        end
        spms_pkg::SPMS_PG_SECOND: begin
          if (last_tick) begin
            state_r <= spms_pkg::SPMS_PG_IDLE;
          end else begin
            cnt_r <= cnt_r - spms_pkg::ONE_CNT;
          end
        end
        default: begin
          state_r <= spms_pkg::SPMS_PG_IDLE;
        end
      endcase
    end
  end

  // line drive follows the sequencer edge for edge, from flops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pulse_r <= '0;
    end else if ((state_r == spms_pkg::SPMS_PG_IDLE) && start) begin
      pulse_r <= '{pos: pos_first_nxt, neg: !pos_first_nxt};
    end else if ((state_r == spms_pkg::SPMS_PG_FIRST) && last_tick) begin
      pulse_r <= '{pos: !pos_first_r, neg: pos_first_r};
    end else if ((state_r == spms_pkg::SPMS_PG_SECOND) && last_tick) begin
      pulse_r <= '0;
    end
  end

  assign pulse = pulse_r;
  assign busy = (state_r != spms_pkg::SPMS_PG_IDLE);
  // done marks the last cycle of the second half, so governors load in time
  assign done = (state_r == spms_pkg::SPMS_PG_SECOND) && last_tick;

endmodule : spms_pulse_gen

// ==== rtl/spms_serial_port.sv ====
/*
  spms_serial_port: strap-driven serial port mode selection, 4-wire spi
  command intake on the link clock, open-drain sdo and gpio drive, and the
  isolated pulse transmitter with its spacing governors and reversal block.
  Assumes straps are static board ties and link_sck runs only inside frames.
  // Functional notes
  // - interface strap high: port a isolated pulse pair; low: port a is spi.
  // - topology strap high selects daisy chain; low selects parallel addressed chips.
  // - parallel mode: port b pins are chip id; only matching commands answered.
  // - port b isolated port enabled only in daisy chain mode.
  // - spi chip select active low frames transfers; clock and data in are inputs.
  // - serial data out only pulls low; external pull-up gives the high.
  // - six gpio pins read as inputs, drive open-drain low or release.
  // - hold off chip-select fall pulse at least 0.6 us after rise pulse.
  // - hold off chip-select pulse at least 0.8 us after last data pulse.
  // - after port direction reversal, block the old direction for 2 us.
*/
`timescale 1ns/1ps
module spms_serial_port (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic interface_type_strap,
  input wire logic chain_topology_strap,
  input wire logic [spms_pkg::ID_W-1:0] chip_id_straps,
  input wire logic link_sck,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo_drive,
  output logic sdo_oe,
  input wire logic [spms_pkg::GPIO_N-1:0] gpio_pins,
  output logic [spms_pkg::GPIO_N-1:0] gpio_drive,
  output logic [spms_pkg::GPIO_N-1:0] gpio_oe,
  input wire logic [spms_pkg::GPIO_N-1:0] gpio_pull_low,
  output logic [spms_pkg::GPIO_N-1:0] gpio_level,
  input wire logic tx_valid,
  input spms_pkg::spms_tx_req_t tx_req,
  output logic tx_ready,
  output spms_pkg::spms_pulse_t port_a_pulse_pair,
  output spms_pkg::spms_pulse_t port_b_pulse_pair,
  output logic port_a_iso_en,
  output logic port_b_en,
  output spms_pkg::spms_cfg_t cfg,
  output logic cmd_valid,
  output logic [spms_pkg::CMD_W-1:0] cmd_word,
  output logic cmd_for_me
);

  // core domain state
  spms_pkg::spms_cfg_t cfg_meta_r;
  spms_pkg::spms_cfg_t cfg_r;
  logic [spms_pkg::GPIO_N-1:0] gpio_meta_r;
  logic [spms_pkg::GPIO_N-1:0] gpio_sync_r;
  logic [spms_pkg::GPIO_N-1:0] gpio_oe_r;
  logic tgl_meta_r;
  logic tgl_sync_r;
  logic tgl_seen_r;
  logic cmd_valid_r;
  logic [spms_pkg::CMD_W-1:0] cmd_word_r;
  logic cmd_for_me_r;
  logic [spms_pkg::CNT_W-1:0] sel_gap_r;
  logic [spms_pkg::CNT_W-1:0] data_gap_r;
  logic [spms_pkg::CNT_W-1:0] rev_cnt_r;
  logic rev_port_r;
  logic cur_port_r;
  spms_pkg::spms_kind_t cur_kind_r;
  logic sent_r;
  spms_pkg::spms_pulse_t port_a_r;
  spms_pkg::spms_pulse_t port_b_r;
  spms_pkg::spms_pulse_t pg_pulse;
  logic pg_busy;
  logic pg_done;
  logic accept;
  logic is_cs_req;
  logic gov_block;
  logic rev_block;
  logic tgl_edge;

  // link domain state
  logic frame_rst;
  spms_pkg::spms_cfg_t link_cfg_meta_r;
  spms_pkg::spms_cfg_t link_cfg_r;
  logic [3:0] bit_cnt_r;
  logic [spms_pkg::CMD_W-1:0] rx_shift_r;
  logic [spms_pkg::CMD_W-1:0] tx_shift_r;
  logic addressed_r;
  logic sdo_oe_r;
  logic [spms_pkg::CMD_W-1:0] cmd_hold_r;
  logic cmd_tgl_r;
  logic [spms_pkg::CMD_W-1:0] rx_byte;
  logic [spms_pkg::CMD_W-1:0] status_byte;
  logic addr_hit;

  // straps pass two flops; being static ties they need nothing more
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_meta_r <= spms_pkg::CFG_RESET;
      cfg_r <= spms_pkg::CFG_RESET;
    end else begin
      cfg_meta_r <= '{interface_type_strap, chain_topology_strap, chip_id_straps};
      cfg_r <= cfg_meta_r;
    end
  end

  assign cfg = cfg_r;
  assign port_a_iso_en = cfg_r.iso_mode;
  assign port_b_en = cfg_r.daisy_mode;

  // gpio: inputs synchronised, outputs open-drain (low or released)
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gpio_meta_r <= '0;
      gpio_sync_r <= '0;
      gpio_oe_r <= '0;
    end else begin
      gpio_meta_r <= gpio_pins;
      gpio_sync_r <= gpio_meta_r;
      gpio_oe_r <= gpio_pull_low;
    end
  end

  assign gpio_level = gpio_sync_r;
  assign gpio_drive = '0;
  assign gpio_oe = gpio_oe_r;

  // frame logic is cleared by chip select itself, since the clock stops
  assign frame_rst = reset || chip_select_n;

  // config reaches the link domain through two flops on link_sck; after
  // each reset the first two edges of the next frame may see reset cfg
  always_ff @(posedge link_sck or posedge reset) begin
    if (reset) begin
      link_cfg_meta_r <= spms_pkg::CFG_RESET;
      link_cfg_r <= spms_pkg::CFG_RESET;
    end else begin
      link_cfg_meta_r <= cfg_r;
      link_cfg_r <= link_cfg_meta_r;
    end
  end

  assign rx_byte = {rx_shift_r[spms_pkg::CMD_W-2:0], sdi};
  assign addr_hit = (rx_byte[spms_pkg::CMD_ADDR_LSB +: spms_pkg::ID_W] == link_cfg_r.chip_id);
  // answer byte: mode bits on top, strapped chip id in the low nibble
  assign status_byte = {link_cfg_r.iso_mode, link_cfg_r.daisy_mode, 2'b00, link_cfg_r.chip_id};

  // spi shifter: command byte in, status byte out on the open-drain line
  always_ff @(posedge link_sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_r <= 4'h0;
      rx_shift_r <= '0;
      tx_shift_r <= '1;
      addressed_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      rx_shift_r <= rx_byte;
      if (bit_cnt_r == spms_pkg::BIT_LAST) begin
        bit_cnt_r <= spms_pkg::BIT_DONE;
        addressed_r <= !link_cfg_r.iso_mode && (link_cfg_r.daisy_mode || addr_hit);
        sdo_oe_r <= !link_cfg_r.iso_mode && (link_cfg_r.daisy_mode || addr_hit)
                    && !status_byte[spms_pkg::CMD_W-1];
        tx_shift_r <= {status_byte[spms_pkg::CMD_W-2:0], 1'b1};
      end else if (bit_cnt_r == spms_pkg::BIT_DONE) begin
        sdo_oe_r <= addressed_r && !tx_shift_r[spms_pkg::CMD_W-1];
        tx_shift_r <= {tx_shift_r[spms_pkg::CMD_W-2:0], 1'b1};
      end else begin
        bit_cnt_r <= bit_cnt_r + spms_pkg::BIT_ONE;
      end
    end
  end

  // sdo never drives high; a zero bit turns the pull-down on
  assign sdo_drive = 1'b0;
  assign sdo_oe = sdo_oe_r;

  // command word held until the next frame; toggle marks a new one
  always_ff @(posedge link_sck or posedge reset) begin
    if (reset) begin
      cmd_hold_r <= '0;
      cmd_tgl_r <= 1'b0;
    end else if (!chip_select_n && (bit_cnt_r == spms_pkg::BIT_LAST) && !link_cfg_r.iso_mode) begin
      cmd_hold_r <= rx_byte;
      cmd_tgl_r <= !cmd_tgl_r;
    end
  end

  // toggle crossing into the core domain
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_meta_r <= cmd_tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  assign tgl_edge = tgl_sync_r ^ tgl_seen_r;

  // word is stable long before the toggle lands, so it is sampled directly
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmd_valid_r <= 1'b0;
      cmd_word_r <= '0;
      cmd_for_me_r <= 1'b0;
    end else begin
      cmd_valid_r <= tgl_edge;
      if (tgl_edge) begin
        cmd_word_r <= cmd_hold_r;
        cmd_for_me_r <= cfg_r.daisy_mode
          || (cmd_hold_r[spms_pkg::CMD_ADDR_LSB +: spms_pkg::ID_W] == cfg_r.chip_id);
      end
    end
  end

  assign cmd_valid = cmd_valid_r;
  assign cmd_word = cmd_word_r;
  assign cmd_for_me = cmd_for_me_r;

  // transmit admission: mode, port, governors and reversal window
  assign is_cs_req = (tx_req.kind == spms_pkg::SPMS_CS_RISE) || (tx_req.kind == spms_pkg::SPMS_CS_FALL);
  assign gov_block = ((tx_req.kind == spms_pkg::SPMS_CS_FALL) && (sel_gap_r != spms_pkg::ZERO_CNT))
                     || (is_cs_req && (data_gap_r != spms_pkg::ZERO_CNT));
  assign rev_block = (rev_cnt_r != spms_pkg::ZERO_CNT) && (tx_req.port_b == rev_port_r);
  assign tx_ready = cfg_r.iso_mode && !pg_busy
                    && (!tx_req.port_b || cfg_r.daisy_mode)
                    && !gov_block && !rev_block;
  assign accept = tx_valid && tx_ready;

  spms_pulse_gen u_pulse_gen (
    .core_clk(core_clk),
    .reset(reset),
    .start(accept),
    .kind(tx_req.kind),
    .pulse(pg_pulse),
    .busy(pg_busy),
    .done(pg_done)
  );

  // remember the symbol in flight and the port it goes out on
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cur_kind_r <= spms_pkg::SPMS_CS_RISE;
      cur_port_r <= 1'b0;
      sent_r <= 1'b0;
    end else if (accept) begin
      cur_kind_r <= tx_req.kind;
      cur_port_r <= tx_req.port_b;
      sent_r <= 1'b1;
    end
  end

  // spacing after a chip-select rise pulse, counted from its end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sel_gap_r <= spms_pkg::ZERO_CNT;
    end else if (pg_done && (cur_kind_r == spms_pkg::SPMS_CS_RISE)) begin
      sel_gap_r <= spms_pkg::SEL_SPACING_CNT;
    end else if (sel_gap_r != spms_pkg::ZERO_CNT) begin
      sel_gap_r <= sel_gap_r - spms_pkg::ONE_CNT;
    end
  end

  // spacing after a data pulse before any chip-select pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_gap_r <= spms_pkg::ZERO_CNT;
    end else if (pg_done && ((cur_kind_r == spms_pkg::SPMS_DATA0) || (cur_kind_r == spms_pkg::SPMS_DATA1))) begin
      data_gap_r <= spms_pkg::DATA_SEL_CNT;
    end else if (data_gap_r != spms_pkg::ZERO_CNT) begin
      data_gap_r <= data_gap_r - spms_pkg::ONE_CNT;
    end
  end

  // reversal: a send on the other port shuts the old port for the window
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rev_cnt_r <= spms_pkg::ZERO_CNT;
      rev_port_r <= 1'b0;
    end else if (accept && sent_r && (tx_req.port_b != cur_port_r)) begin
      rev_cnt_r <= spms_pkg::BLOCK_CNT;
      rev_port_r <= cur_port_r;
    end else if (rev_cnt_r != spms_pkg::ZERO_CNT) begin
      rev_cnt_r <= rev_cnt_r - spms_pkg::ONE_CNT;
    end
  end

  // steer the shaped pulse to its port; one flop stage keeps outputs clean
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_a_r <= '0;
      port_b_r <= '0;
    end else begin
      port_a_r <= cur_port_r ? '0 : pg_pulse;
      port_b_r <= cur_port_r ? pg_pulse : '0;
    end
  end

  assign port_a_pulse_pair = port_a_r;
  assign port_b_pulse_pair = port_b_r;

  // helper counters: cycles since the events the governors time from
  logic [spms_pkg::CNT_W-1:0] since_rise_r;
  logic [spms_pkg::CNT_W-1:0] since_data_r;
  logic [spms_pkg::CNT_W-1:0] since_rev_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      since_rise_r <= spms_pkg::SAT_CNT;
      since_data_r <= spms_pkg::SAT_CNT;
      since_rev_r <= spms_pkg::SAT_CNT;
    end else begin
      if (pg_done && (cur_kind_r == spms_pkg::SPMS_CS_RISE)) since_rise_r <= spms_pkg::ZERO_CNT;
      else if (since_rise_r != spms_pkg::SAT_CNT) since_rise_r <= since_rise_r + spms_pkg::ONE_CNT;
      if (pg_done && cur_kind_r[1]) since_data_r <= spms_pkg::ZERO_CNT;
      else if (since_data_r != spms_pkg::SAT_CNT) since_data_r <= since_data_r + spms_pkg::ONE_CNT;
      if (accept && sent_r && (tx_req.port_b != cur_port_r)) since_rev_r <= spms_pkg::ZERO_CNT;
      else if (since_rev_r != spms_pkg::SAT_CNT) since_rev_r <= since_rev_r + spms_pkg::ONE_CNT;
    end
  end

  sequence seq_cs_rise_a;
    accept && (tx_req.kind == spms_pkg::SPMS_CS_RISE) && !tx_req.port_b;
  endsequence

  sequence seq_long_pos;
    (port_a_r.pos && !port_a_r.neg) [*3];
  endsequence

  sequence seq_long_neg;
    (port_a_r.neg && !port_a_r.pos) [*3];
  endsequence

  chk_tx_iso_only: assert property (@(posedge core_clk) disable iff (reset)
    accept |-> cfg_r.iso_mode) else $error("pulse sent while port a in spi mode");

  chk_cs_pulse_shape: assert property (@(posedge core_clk) disable iff (reset)
    seq_cs_rise_a |-> ##2 seq_long_pos ##1 seq_long_neg ##1 (!port_a_r.pos && !port_a_r.neg))
    else $error("chip-select rise pulse shape wrong");

  chk_daisy_accepts: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid_r && cfg_r.daisy_mode) |-> cmd_for_me_r) else $error("daisy command not taken");

  chk_parallel_addr: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid_r && !cfg_r.daisy_mode) |->
    (cmd_for_me_r == (cmd_word_r[spms_pkg::CMD_ADDR_LSB +: spms_pkg::ID_W] == cfg_r.chip_id)))
    else $error("address match wrong in parallel mode");

  chk_portb_daisy: assert property (@(posedge core_clk) disable iff (reset)
    (port_b_r.pos || port_b_r.neg || (accept && tx_req.port_b)) |-> cfg_r.daisy_mode)
    else $error("port b active outside daisy mode");

  chk_sdo_in_frame: assert property (@(posedge link_sck) disable iff (frame_rst)
    sdo_oe_r |-> (addressed_r && (bit_cnt_r == spms_pkg::BIT_DONE)))
    else $error("sdo driven outside an addressed answer");

  chk_sdo_pulls_low: assert property (@(posedge link_sck) disable iff (frame_rst)
    ((bit_cnt_r == spms_pkg::BIT_DONE) && addressed_r) |=>
    ((sdo_oe_r == !$past(tx_shift_r[spms_pkg::CMD_W-1])) && !sdo_drive))
    else $error("sdo answer bit wrong");

  chk_gpio_open_drain: assert property (@(posedge core_clk) disable iff (reset)
    $rose(gpio_pull_low[0]) |=> (gpio_oe[0] && !gpio_drive[0]) ##1
    (gpio_oe[0] == $past(gpio_pull_low[0])))
    else $error("gpio not pulled low on request");

  chk_sel_spacing: assert property (@(posedge core_clk) disable iff (reset)
    (accept && (tx_req.kind == spms_pkg::SPMS_CS_FALL)) |-> (since_rise_r >= spms_pkg::SEL_SPACING_CNT))
    else $error("chip-select fall too soon after rise");

  chk_data_to_sel: assert property (@(posedge core_clk) disable iff (reset)
    (accept && is_cs_req) |-> (since_data_r >= spms_pkg::DATA_SEL_CNT))
    else $error("chip-select pulse too soon after data");

  chk_reversal_block: assert property (@(posedge core_clk) disable iff (reset)
    (accept && (since_rev_r != spms_pkg::SAT_CNT) && (tx_req.port_b == rev_port_r))
    |-> (since_rev_r >= spms_pkg::BLOCK_CNT)) else $error("old direction used inside block window");

endmodule : spms_serial_port

// ==== verification/spms_host_model.sv ====
/*
  spms_host_model: spi host on the far side of port a, 4-wire mode.
  Assumes the bench calls frame only while the block is strapped for spi;
  sdo_line is the wire level with the board pull-up already applied.
*/
`timescale 1ns/1ps
module spms_host_model (
  output logic link_sck,
  output logic chip_select_n,
  output logic sdi,
  input wire logic sdo_line
);
  // bus idles deselected; the clock stands low outside frames
  initial begin
    link_sck = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end

  // one frame: command msb first, status byte read back on edges 8..15
  task automatic frame(input logic [7:0] cmd, output logic [7:0] resp);
    resp = 8'h00;
    #17 chip_select_n = 1'b0;
    #1000;
    for (int i = 0; i < 16; i++) begin
      sdi = (i < 8) ? cmd[7-i] : ~sdi; // past the command the data line is junk
      #62.5 link_sck = 1'b1;
      #62.5 link_sck = 1'b0;
      if (i >= 7 && i <= 14) resp = {resp[6:0], sdo_line};
    end
    #800 chip_select_n = 1'b1;
    sdi = ~sdi; // deselected: never leave a stale level on the line
    #700;
  endtask : frame
endmodule : spms_host_model

// ==== verification/spms_serial_port_tb.sv ====
/*
  spms_serial_port_tb: self-checking bench for spms_serial_port.
  Assumes the host model drives the spi pins; straps change only under reset.
*/
`timescale 1ns/1ps
module spms_serial_port_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic iso = 1'b0;
  logic daisy = 1'b0;
  logic tx_valid = 1'b0;
  logic [3:0] id = 4'h0;
  logic [5:0] pull = 6'h00, gdrv = 6'h00, g_oe, g_o, g_lvl;
  logic sck, csn, sdi, sdo_o, sdo_oe, sdo_line, tx_ready, a_en, b_en, cmd_valid, for_me;
  logic [7:0] cmd_word, resp, cmd;
  spms_pkg::spms_tx_req_t tx_req = 3'h0;
  spms_pkg::spms_pulse_t pa, pb;
  spms_pkg::spms_cfg_t cfg;
  logic [8:0] expq[$];
  // {first request, second request, 1'b0, port a pair two cycles after the first take}
  logic [8:0] seq [3] = '{9'h012, 9'h102, 9'h191};
  int miscompares = 0, tests_run = 0, cyc = 0, t0, t1;

  always #25 core_clk = ~core_clk;
  assign sdo_line = sdo_oe ? sdo_o : 1'b1; // board pull-up

  spms_host_model i_host (.link_sck(sck), .chip_select_n(csn), .sdi(sdi), .sdo_line(sdo_line));

  spms_serial_port i_dut (.core_clk(core_clk), .reset(reset), .interface_type_strap(iso),
    .chain_topology_strap(daisy), .chip_id_straps(id), .link_sck(sck), .chip_select_n(csn),
    .sdi(sdi), .sdo_drive(sdo_o), .sdo_oe(sdo_oe), .gpio_pins(gdrv & ~g_oe), .gpio_drive(g_o),
    .gpio_oe(g_oe), .gpio_pull_low(pull), .gpio_level(g_lvl), .tx_valid(tx_valid),
    .tx_req(tx_req), .tx_ready(tx_ready), .port_a_pulse_pair(pa), .port_b_pulse_pair(pb),
    .port_a_iso_en(a_en), .port_b_en(b_en), .cfg(cfg), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .cmd_for_me(for_me));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // straps move only while reset holds the block, as a board would
  task automatic setup(input logic i, input logic d);
    reset = 1'b1;
    iso = i;
    daisy = d;
    id = 4'($urandom);
    repeat (3) @(posedge core_clk);
    #2 reset = 1'b0;
    repeat (4) @(posedge core_clk);
    #2 chk(32'(cfg), {26'h0, i, d, id});
    chk(32'({a_en, b_en}), {30'h0, i, d});
  endtask : setup

  // hold the request until taken; t is the take cycle
  task automatic send(input logic [2:0] r, output int t);
    int n;
    n = 0;
    tx_req = r;
    tx_valid = 1'b1;
    #1;
    while (tx_ready !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #3 n++;
    end
    @(posedge core_clk);
    #2 t = cyc;
    tx_valid = 1'b0;
    @(posedge core_clk);
    #2;
  endtask : send

  // each reported command is checked against the oldest note
  always @(posedge core_clk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      if (expq.size() == 0)
        chk(32'h0, 32'h1);
      else
        chk(32'({cmd_word, for_me}), 32'(expq.pop_front()));
    end
    if (cyc == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'he7bf));
    repeat (12) @(posedge core_clk);
    #2 reset = 1'b0;
    @(posedge core_clk);
    #2 setup(1'b0, 1'b0);
    // first pass raises pin 0 so its open-drain check is reached
    for (int k = 0; k < 2; k++) begin
      pull = {5'($urandom), k == 0};
      gdrv = 6'h3f;
      repeat (2) @(posedge core_clk);
      #2 chk(32'({g_oe, g_o}), {20'h0, pull, 6'h00});
      repeat (3) @(posedge core_clk);
      #2 chk(32'(g_lvl), {26'h0, ~pull});
    end
    cmd = {id, 4'($urandom)};
    expq.push_back({cmd, 1'b1});
    i_host.frame(cmd, resp);
    chk(32'(resp), {28'h0, id});
    cmd = {~id, 4'($urandom)};
    expq.push_back({cmd, 1'b0});
    i_host.frame(cmd, resp);
    chk(32'(resp), 32'hff);
    setup(1'b0, 1'b1);
    cmd = 8'($urandom);
    expq.push_back({cmd, 1'b1});
    i_host.frame(cmd, resp);
    chk(32'(resp), {24'h0, 4'h4, id});
    setup(1'b1, 1'b0);
    // minimum pulse spacing, measured take to take
    foreach (seq[k]) begin
      send(seq[k][8:6], t0);
      @(posedge core_clk);
      #2 chk(32'(pa), 32'(seq[k][1:0]));
      send(seq[k][5:3], t1);
      chk(32'(t1 - t0 >= 19 && t1 - t0 <= 26), 32'h1);
    end
    setup(1'b1, 1'b1);
    send(3'b110, t0);
    send(3'b111, t0);
    chk(32'(pb), 32'h2);
    send(3'b110, t1);
    chk(32'(t1 - t0 >= 40 && t1 - t0 <= 202), 32'h1);
    repeat (20) @(posedge core_clk);
    chk(32'(expq.size()), 32'h0);
    tally_and_finish();
  end
endmodule : spms_serial_port_tb
